// ---- ipv_vectoring.sv ----
`timescale 1ns/10ps
module ipv_vectoring
  import ipv_pkg::*;
#(
  parameter int VEC_N = IPV_VEC_N
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [VEC_N-1:0] irq_req,
  input wire logic [VEC_N-1:0][IPV_CFG_W-1:0] prio_cfg,
  input wire logic [1:0] core_level,
  input wire logic [IPV_ADDR_W-1:0] vector_table_base,
  input wire logic wdog_reset_cause,
  input wire logic core_ack,
  input wire logic [2*16-1:0] entry_word,
  output logic vec_valid_reg,
  output logic [IPV_VEC_W-1:0] vec_num_reg,
  output logic [IPV_RANK_W-1:0] vec_rank_reg,
  output logic [IPV_ADDR_W-1:0] fetch_addr_reg,
  output logic [IPV_ADDR_W-1:0] jump_target_reg
);

  // rank 0 is level -1, rank 4 is level 3
  function automatic logic [IPV_RANK_W-1:0] rank_of(input int v,
                                                     input logic [IPV_CFG_W-1:0] cfg);
    logic [IPV_CFG_W-1:0] c;
    c = cfg;
    if (v >= IPV_FIX3_LO && v <= IPV_FIX3_HI) begin
      rank_of = IPV_RANK_L3;
    end else if ((v >= IPV_DBG_LO && v <= IPV_DBG_HI) ||
                 (v >= IPV_PWR_LO && v <= IPV_PWR_HI)) begin
      if (c < IPV_CFG_MIN_DBG) c = IPV_CFG_MIN_DBG;
      rank_of = IPV_RANK_L0 + IPV_RANK_W'(c);
    end else if (v == IPV_SW2) begin
      rank_of = IPV_RANK_L2;
    end else if (v == IPV_SW1) begin
      rank_of = IPV_RANK_L1;
    end else if (v == IPV_SW0) begin
      rank_of = IPV_RANK_L0;
    end else if (v >= IPV_PER_LO && v <= IPV_PER_HI) begin
      if (c > IPV_CFG_MAX_PER) c = IPV_CFG_MAX_PER;
      rank_of = IPV_RANK_L0 + IPV_RANK_W'(c);
    end else begin
      rank_of = IPV_RANK_NEG1;
    end
  endfunction

  function automatic logic requestable(input int v);
    requestable = (v >= IPV_FIX3_LO) && (v != IPV_RSVD);
  endfunction

  // base plus two words per entry
  function automatic logic [IPV_ADDR_W-1:0] entry_addr(
    input logic [IPV_ADDR_W-1:0] base,
    input logic [IPV_VEC_W-1:0] n
  );
    entry_addr = base + (IPV_ADDR_W'(n) << IPV_ENTRY_SHIFT);
  endfunction

  // level -1 only gets through with the core fully open
  function automatic logic unmasked(
    input logic [IPV_RANK_W-1:0] r,
    input logic [1:0] lvl
  );
    unmasked = (r > IPV_RANK_W'(lvl)) ||
               (r == IPV_RANK_NEG1 && lvl == IPV_CORE_LVL_OPEN);
  endfunction

  // descending scan with >= lets the lower index win ties;
  // all it reads comes in as arguments, so any input change re-arbitrates
  function automatic ipv_vec_t arbitrate(
    input logic [VEC_N-1:0] p,
    input logic [VEC_N-1:0] elig,
    input logic [VEC_N-1:0][IPV_RANK_W-1:0] rk,
    input logic [IPV_ADDR_W-1:0] base
  );
    ipv_vec_t best;
    logic found;
    best = '0;
    found = 1'b0;
    for (int i = VEC_N - 1; i >= 0; i--) begin
      if (p[i] && elig[i] && (!found || rk[i] >= best.rank)) begin
        found = 1'b1;
        best.num = IPV_VEC_W'(i);
        best.rank = rk[i];
      end
    end
    best.addr = entry_addr(base, best.num);
    arbitrate = best;
  endfunction

  // only the pending bits, state_reg and the output registers are state
  logic [VEC_N-1:0][IPV_RANK_W-1:0] rank_vec;
  logic [VEC_N-1:0] elig_vec;
  logic [VEC_N-1:0] pend_reg;
  logic [VEC_N-1:0] pend_next;
  ipv_state_t state_reg;
  ipv_state_t state_next;
  ipv_vec_t pres_next;

  // per-vector rank and mask, rebuilt whenever a level setting moves
  always_comb begin
    for (int i = 0; i < VEC_N; i++) begin
      rank_vec[i] = rank_of(i, prio_cfg[i]);
      elig_vec[i] = requestable(i) && unmasked(rank_of(i, prio_cfg[i]), core_level);
    end
  end

  wire ipv_vec_t winner =
    arbitrate(pend_reg, elig_vec, rank_vec, vector_table_base);
  wire logic any_win = |(pend_reg & elig_vec);
  wire logic taken = (state_reg == IPV_ST_PRESENT) && core_ack;
  wire logic [VEC_N-1:0] clr_mask =
    taken ? (VEC_N'(1) << vec_num_reg) : '0;
  wire logic [IPV_VEC_W-1:0] boot_vec =
    wdog_reset_cause ? IPV_VEC_WDOG_RST : IPV_VEC_CHIP_RST;
  // entry holds only a 19-bit target; software must use jumps in slots 0 and 1
  wire logic [IPV_ADDR_W-1:0] target_lim =
    IPV_ADDR_W'(entry_word[IPV_TARGET_W-1:0]);

  // a new request in the clearing cycle survives
  assign pend_next = (pend_reg & ~clr_mask) | irq_req;

  // no preemption: a higher request waits for the ack of the one shown
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IPV_ST_BOOT: begin
        if (core_ack) begin
          state_next = IPV_ST_IDLE;
        end
      end
      IPV_ST_IDLE: begin
        if (any_win) begin
          state_next = IPV_ST_PRESENT;
        end
      end
      IPV_ST_PRESENT: begin
        if (core_ack) begin
          state_next = IPV_ST_IDLE;
        end
      end
      default: begin
        state_next = IPV_ST_IDLE;
      end
    endcase
  end

  // fields freeze while shown; boot follows the reset cause until taken
  always_comb begin
    pres_next.num = vec_num_reg;
    pres_next.rank = vec_rank_reg;
    pres_next.addr = fetch_addr_reg;
    case (state_reg)
      IPV_ST_BOOT: begin
        if (!core_ack) begin
          pres_next.num = boot_vec;
          pres_next.rank = IPV_RANK_L3;
          pres_next.addr = entry_addr(vector_table_base, boot_vec);
        end
      end
      IPV_ST_IDLE: begin
        if (any_win) begin
          pres_next = winner;
        end
      end
      default: begin
        pres_next.num = vec_num_reg;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= IPV_ST_BOOT;
      pend_reg <= '0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
    end
  end

  // valid follows the next state so it never leads the fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_valid_reg <= 1'b0;
    end else begin
      vec_valid_reg <= (state_next != IPV_ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_num_reg <= '0;
      vec_rank_reg <= '0;
      fetch_addr_reg <= '0;
    end else begin
      vec_num_reg <= pres_next.num;
      vec_rank_reg <= pres_next.rank;
      fetch_addr_reg <= pres_next.addr;
    end
  end

  // one cycle behind the entry word that the core hands back
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jump_target_reg <= '0;
    end else begin
      jump_target_reg <= target_lim;
    end
  end

endmodule

// ---- ipv_pkg.sv ----
package ipv_pkg;
  localparam int IPV_VEC_N = 64;
  localparam int IPV_VEC_W = 6;
  localparam int IPV_ADDR_W = 21;
  localparam int IPV_TARGET_W = 19;
  localparam int IPV_ENTRY_SHIFT = 1;
  localparam int IPV_RANK_W = 3;
  localparam int IPV_CFG_W = 2;
  localparam logic [2:0] IPV_RANK_NEG1 = 3'h0;
  localparam logic [2:0] IPV_RANK_L0 = 3'h1;
  localparam logic [2:0] IPV_RANK_L1 = 3'h2;
  localparam logic [2:0] IPV_RANK_L2 = 3'h3;
  localparam logic [2:0] IPV_RANK_L3 = 3'h4;
  localparam logic [1:0] IPV_CFG_MIN_DBG = 2'h1;
  localparam logic [1:0] IPV_CFG_MAX_PER = 2'h2;
  localparam logic [1:0] IPV_CORE_LVL_OPEN = 2'h0;
  localparam logic [5:0] IPV_VEC_CHIP_RST = 6'h00;
  localparam logic [5:0] IPV_VEC_WDOG_RST = 6'h01;
  localparam int IPV_FIX3_LO = 2;
  localparam int IPV_FIX3_HI = 5;
  localparam int IPV_DBG_LO = 6;
  localparam int IPV_DBG_HI = 10;
  localparam int IPV_SW2 = 11;
  localparam int IPV_SW1 = 12;
  localparam int IPV_SW0 = 13;
  localparam int IPV_RSVD = 14;
  localparam int IPV_PWR_LO = 15;
  localparam int IPV_PWR_HI = 16;
  localparam int IPV_PER_LO = 17;
  localparam int IPV_PER_HI = 62;
  localparam int IPV_SWLP = 63;

  typedef struct packed {
    logic [IPV_VEC_W-1:0] num;
    logic [IPV_RANK_W-1:0] rank;
    logic [IPV_ADDR_W-1:0] addr;
  } ipv_vec_t;

  typedef enum logic [2:0] {
    IPV_ST_BOOT = 3'h1,
    IPV_ST_IDLE = 3'h2,
    IPV_ST_PRESENT = 3'h4
  } ipv_state_t;
endpackage

// ---- ipv_core_model.sv ----
`timescale 1ns/10ps
module ipv_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic vec_valid_reg,
  input wire logic [5:0] vec_num_reg,
  input wire logic [20:0] fetch_addr_reg,
  output logic core_ack,
  output logic [31:0] entry_word
);
  // one-cycle accept, never twice in a row
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) core_ack <= 1'b0;
    else core_ack <= vec_valid_reg && !core_ack;
  end
  // reset slots hold a jump, others a call; set top bits catch a wide target
  assign entry_word = {vec_num_reg < 6'h02 ? 3'h5 : 3'h6, 8'hff, fetch_addr_reg};
endmodule

// ---- ipv_chk_sva.sv ----
`timescale 1ns/10ps
module ipv_chk
  import ipv_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wdog_reset_cause,
  input wire logic core_ack,
  input wire logic [2*16-1:0] entry_word,
  input wire logic [IPV_ADDR_W-1:0] vector_table_base,
  input wire logic vec_valid_reg,
  input wire logic [IPV_VEC_W-1:0] vec_num_reg,
  input wire logic [IPV_RANK_W-1:0] vec_rank_reg,
  input wire logic [IPV_ADDR_W-1:0] fetch_addr_reg,
  input wire logic [IPV_ADDR_W-1:0] jump_target_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_taken; vec_valid_reg && core_ack; endsequence
  sequence s_boot; rst_b && !$past(rst_b); endsequence
  addr_map_a: assert property (vec_valid_reg |->
    fetch_addr_reg == vector_table_base + {vec_num_reg, 1'b0}) else $error("bad addr");
  target_width_a: assert property (rst_b && $past(rst_b) |->
    jump_target_reg == {2'h0, $past(entry_word[18:0])}) else $error("bad target");
  boot_slot_a: assert property (s_boot |=>
    vec_valid_reg && vec_rank_reg == IPV_RANK_L3 &&
    vec_num_reg == {5'h0, $past(wdog_reset_cause)}) else $error("bad boot");
  fixed_three_a: assert property (vec_valid_reg && vec_num_reg inside {[2:5]} |->
    vec_rank_reg == IPV_RANK_L3) else $error("bad fixed");
  debug_level_a: assert property (vec_valid_reg && vec_num_reg inside {[6:10]} |->
    vec_rank_reg inside {[IPV_RANK_L1:IPV_RANK_L3]}) else $error("bad debug");
  periph_level_a: assert property (vec_valid_reg && vec_num_reg inside {[17:62]} |->
    vec_rank_reg inside {[IPV_RANK_L0:IPV_RANK_L2]}) else $error("bad periph");
  hold_vector_a: assert property (vec_valid_reg && !core_ack |=>
    vec_valid_reg && $stable(vec_num_reg)) else $error("dropped");
  ack_gap_a: assert property (s_taken |=> !vec_valid_reg) else $error("no gap");
endmodule

// ---- test_interrupt_priority_vectoring.sv ----
`timescale 1ns/10ps
module test_interrupt_priority_vectoring;
  import ipv_pkg::*;
  logic clk = 0, rst_b = 0, w = 0, ack, v;
  logic [63:0] irq = '0;
  logic [63:0][1:0] cfg = '0;
  logic [1:0] lvl = '0;
  logic [20:0] base = 21'h1f0400, fa, jt;
  logic [31:0] ew;
  logic [5:0] n;
  logic [2:0] r;
  int err_total = 0, checks_done = 0;
  // winner, its cfg, rank, loser, its cfg, rank
  logic [5:0] rows [7][6] = '{'{3, 0, 4, 20, 2, 3},
    '{25, 1, 2, 30, 1, 2}, '{11, 0, 3, 62, 2, 3},
    '{13, 0, 1, 63, 0, 0},
    '{40, 3, 3, 7, 0, 2}, '{15, 3, 4, 16, 1, 2},
    '{2, 0, 4, 6, 3, 4}};
  always #50 clk = ~clk;
  ipv_vectoring ipv_vectoring_inst(.clk(clk), .rst_b(rst_b), .irq_req(irq), .prio_cfg(cfg),
    .core_level(lvl), .vector_table_base(base), .wdog_reset_cause(w), .core_ack(ack),
    .entry_word(ew), .vec_valid_reg(v), .vec_num_reg(n), .vec_rank_reg(r),
    .fetch_addr_reg(fa), .jump_target_reg(jt));
  ipv_core_model ipv_core_model_inst(.clk(clk), .rst_b(rst_b), .vec_valid_reg(v),
    .vec_num_reg(n), .fetch_addr_reg(fa), .core_ack(ack), .entry_word(ew));
  task chk(input string s, input logic [20:0] e, input logic [20:0] g);
    checks_done++;
    if (e !== g) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // bounded wait; a missing answer shows as a failed compare
  task wv(input logic l);
    repeat (30) begin
      @(negedge clk);
      if (v === l) return;
    end
    chk("valid", l, v);
  endtask
  task present(input logic [5:0] e, input logic [5:0] rk);
    wv(1'b1);
    chk("num", e, n);
    chk("rank", rk, r);
    chk("addr", 21'(base + 2 * e), fa);
    @(negedge clk);
    chk("target", {2'h0, 19'(base + 2 * e)}, jt);
    wv(1'b0);
  endtask
  task print_verdict();
    $display("mismatches %0d of %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    present(0, 4);
    foreach (rows[i]) begin
      @(posedge clk);
      base <= base + 21'h100;
      cfg[rows[i][0]] <= rows[i][1];
      cfg[rows[i][3]] <= rows[i][4];
      irq[rows[i][0]] <= 1;
      irq[rows[i][3]] <= 1;
      @(posedge clk);
      irq <= '0;
      present(rows[i][0], rows[i][2]);
      present(rows[i][3], rows[i][5]);
    end
    @(posedge clk);
    lvl <= 3;
    irq[20] <= 1;
    @(posedge clk);
    irq <= '0;
    repeat (6) @(negedge clk);
    chk("masked", 0, v);
    @(posedge clk);
    lvl <= 0;
    present(20, 3);
    @(posedge clk);
    rst_b <= 0;
    w <= 1;
    @(negedge clk);
    chk("reset valid", 0, v);
    chk("reset addr", 0, fa);
    @(posedge clk);
    rst_b <= 1;
    present(1, 4);
    print_verdict();
  end
endmodule
bind ipv_vectoring ipv_chk ipv_chk_inst(.clk(clk), .rst_b(rst_b),
  .wdog_reset_cause(wdog_reset_cause), .core_ack(core_ack), .entry_word(entry_word),
  .vector_table_base(vector_table_base), .vec_valid_reg(vec_valid_reg),
  .vec_num_reg(vec_num_reg), .vec_rank_reg(vec_rank_reg),
  .fetch_addr_reg(fetch_addr_reg), .jump_target_reg(jump_target_reg));
